/* File: rtl/tpm_pkg.sv */
// constants and types of the thermal protection monitor
package tpm_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned PERSIST_MS    = 100;
  localparam int unsigned PERSIST_CYC   = PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_MS       = 1;
  localparam int unsigned STEP_CYC      = STEP_MS * (CLK_HZ / 1000);
  // register byte offsets
  localparam logic [5:0] OFS_OVL_MODE   = 6'h00;
  localparam logic [5:0] OFS_PF_SET     = 6'h04;
  localparam logic [5:0] OFS_SENS_TYPE  = 6'h08;
  localparam logic [5:0] OFS_OT_RESP    = 6'h0C;
  localparam logic [5:0] OFS_ALM_THR    = 6'h10;
  localparam logic [5:0] OFS_FLT_THR    = 6'h14;
  localparam logic [5:0] OFS_COOLING    = 6'h18;
  localparam logic [5:0] OFS_CLEAR      = 6'h1C;
  localparam logic [5:0] OFS_STATUS     = 6'h20;
  localparam logic [5:0] OFS_PULSE      = 6'h24;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // overload response modes
  localparam logic [7:0] OVL_MODE_3     = 8'h03;
  localparam logic [7:0] OVL_MODE_12    = 8'h0C;
  localparam logic [7:0] OVL_MODE_13    = 8'h0D;
  // sensor type codes
  localparam logic [7:0] SENS_NONE      = 8'h00;
  localparam logic [7:0] SENS_PTC       = 8'h01;
  localparam logic [7:0] SENS_SI        = 8'h02;
  localparam logic [7:0] SENS_SWITCH    = 8'h04;
  localparam logic [7:0] SENS_PT        = 8'h06;
  // overtemperature response codes
  localparam logic [7:0] OTR_ALARM      = 8'h00;
  localparam logic [7:0] OTR_ILIM       = 8'h01;
  localparam logic [7:0] OTR_FAULT      = 8'h02;
  localparam logic [7:0] OTR_MODEL      = 8'h0C;
  // cooling codes
  localparam logic [7:0] COOL_SHAFT     = 8'h00;
  localparam logic [7:0] COOL_SEP_FAN   = 8'h01;
  localparam logic [7:0] COOL_LIQUID    = 8'h02;
  localparam logic [7:0] COOL_NO_FAN    = 8'h80;
  // resistance limits in ohms
  localparam logic [15:0] SW_OPEN_OHM   = 16'h0064;
  localparam logic [15:0] PTC_HOT_OHM   = 16'h0672;
  localparam logic [15:0] PTC_SHORT_OHM = 16'h0014;
  localparam logic [15:0] WIRE_OHM      = 16'h0848;
  localparam logic [15:0] SI_SHORT_OHM  = 16'h0032;
  localparam logic [15:0] PT_SHORT_OHM  = 16'h025B;
  // evaluated temperature span, degrees
  localparam logic signed [9:0] TEMP_MIN = -10'sh030;
  localparam logic signed [9:0] TEMP_MAX = 10'sh0F8;
  // pulse frequency and derating steps
  localparam logic [7:0] PF_BASE        = 8'h02;
  localparam logic [7:0] DERATE_MAX     = 8'h32;
  // reset values
  localparam logic [7:0] RST_OVL_MODE   = 8'h0C;
  localparam logic [7:0] RST_PF_SET     = 8'h04;
  localparam logic [7:0] RST_OT_RESP    = 8'h0C;
  localparam logic [9:0] RST_ALM_THR    = 10'h082;
  localparam logic [9:0] RST_FLT_THR    = 10'h091;
  typedef enum logic [1:0] {OVL_IDLE, OVL_PULSE, OVL_DERATE, OVL_TRIP} tpm_ovl_t;
endpackage

/* File: rtl/tpm_monitor.sv */
// thermal protection monitor: overload response and motor sensor evaluation
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: mode 3 lowers pulse, holds setpoint current
// RL2: pulse frequency returns to setpoint after overload
// RL3: modes 3/13 trip when reduction fails
// RL4: mode 12: pulse first, then current/speed
// RL5: modes 12/13 no derating from setpoint
// RL6: stage two reduction restored after overload
// RL7: mode 12 trips when both stages fail
// RL8: mode 13 single stage before trip
// RL9: switch open at 100 ohms or more
// RL10: thermistor above 1650 ohms is overtemperature
// RL11: thermistor below 20 ohms alarm, trip later
// RL12: resistive sensors evaluate -48 to 248 degrees
// RL13: overtemp alarm above alarm threshold, response 0
// RL14: overtemp fault on fault threshold or response
// RL15: above 2120 ohms is wire-break
// RL16: silicon below 50 ohms is short-circuit
// RL17: platinum below 603 ohms is short-circuit
// RL18: cooling method codes 0/1/2/128, reset 0
// RL19: sensor type codes 0/1/2/4/6, reset 0
// RL20: response codes 0/1/2/12, reset 12
// RL21: persistence restarts, alarm clears when valid
// RL22: classification registered one clock after sample
module tpm_monitor #(
  parameter logic [19:0] PERSIST_CYC = 20'(tpm_pkg::PERSIST_CYC),
  parameter logic [15:0] STEP_CYC    = 16'(tpm_pkg::STEP_CYC)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [31:0]       araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  input  wire logic              unit_overload,
  input  wire logic              sample_valid,
  input  wire logic [15:0]       sensor_ohms,
  input  wire logic signed [9:0] motor_temp,
  output logic [7:0]             pulse_freq,
  output logic [7:0]             output_derate,
  output logic                   max_cur_at_setpoint,
  output logic                   power_unit_overtemp_trip,
  output logic                   sensor_fault_alarm,
  output logic                   sensor_fault_trip,
  output logic                   motor_overtemp_alarm,
  output logic                   motor_overtemp_fault,
  output logic                   current_limit_reduce
);
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic                   arready;
    logic                   rvalid;
    logic                   aw_full;
    logic                   w_full;
    logic [5:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic [1:0]             bresp;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    logic [7:0]             ovl_mode;
    logic [7:0]             pf_set;
    logic [7:0]             sens_type;
    logic [7:0]             ot_resp;
    logic [7:0]             cooling;
    logic signed [9:0]      alm_thr;
    logic signed [9:0]      flt_thr;
    tpm_pkg::tpm_ovl_t      ovl_st;
    logic [7:0]             pulse_freq;
    logic [7:0]             derate;
    logic                   cur_hold;
    logic                   pu_trip;
    logic [15:0]            step_cnt;
    logic                   step_en;
    logic                   sens_bad;
    logic [19:0]            persist_cnt;
    logic                   sfa;
    logic                   sft;
    logic                   ota;
    logic                   otf;
    logic                   ilim;
  } tpm_state_t;

  tpm_state_t s_reg;
  tpm_state_t s_next;

  function automatic logic [3:0] cool_dec(input logic [7:0] c);
    case (c)
      tpm_pkg::COOL_SHAFT:   cool_dec = 4'h1;
      tpm_pkg::COOL_SEP_FAN: cool_dec = 4'h2;
      tpm_pkg::COOL_LIQUID:  cool_dec = 4'h4;
      tpm_pkg::COOL_NO_FAN:  cool_dec = 4'h8;
      default:               cool_dec = 4'h0;
    endcase
  endfunction

  function automatic logic ovl_supported(input logic [7:0] m);
    ovl_supported = (m == tpm_pkg::OVL_MODE_3) || (m == tpm_pkg::OVL_MODE_12) ||
                    (m == tpm_pkg::OVL_MODE_13);
  endfunction

  function automatic logic signed [9:0] clamp_temp(input logic signed [9:0] t);
    if (t < tpm_pkg::TEMP_MIN)
      clamp_temp = tpm_pkg::TEMP_MIN;
    else if (t > tpm_pkg::TEMP_MAX)
      clamp_temp = tpm_pkg::TEMP_MAX;
    else
      clamp_temp = t;
  endfunction

  function automatic logic [31:0] rd_word(input tpm_state_t s, input logic [5:0] a);
    case (a)
      tpm_pkg::OFS_OVL_MODE:  rd_word = {24'h000000, s.ovl_mode};
      tpm_pkg::OFS_PF_SET:    rd_word = {24'h000000, s.pf_set};
      tpm_pkg::OFS_SENS_TYPE: rd_word = {24'h000000, s.sens_type};
      tpm_pkg::OFS_OT_RESP:   rd_word = {24'h000000, s.ot_resp};
      tpm_pkg::OFS_ALM_THR:   rd_word = {22'h000000, s.alm_thr};
      tpm_pkg::OFS_FLT_THR:   rd_word = {22'h000000, s.flt_thr};
      tpm_pkg::OFS_COOLING:   rd_word = {24'h000000, s.cooling};
      tpm_pkg::OFS_STATUS:
        rd_word = {19'h00000, cool_dec(s.cooling), s.ovl_st, s.cur_hold, s.pu_trip,
                   s.ilim, s.otf, s.ota, s.sft, s.sfa};
      tpm_pkg::OFS_PULSE:     rd_word = {16'h0000, s.derate, s.pulse_freq};
      default:                rd_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [5:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= tpm_pkg::OFS_PULSE);
  endfunction

  always_comb
  begin
    logic [15:0]       wv;
    logic              clr;
    logic              bad;
    logic              hot;
    logic              alm;
    logic              flt;
    logic signed [9:0] t;
    wv = 16'h0000;
    clr = 1'b0;
    bad = 1'b0;
    hot = 1'b0;
    alm = 1'b0;
    flt = 1'b0;
    t = clamp_temp(motor_temp);
    s_next = s_reg;
    // slow step enable for pulse and derate ramps
    s_next.step_en = 1'b0;
    if (s_reg.step_cnt >= STEP_CYC - 16'h0001)
    begin
      s_next.step_cnt = 16'h0000;
      s_next.step_en = 1'b1;
    end
    else
      s_next.step_cnt = s_reg.step_cnt + 16'h0001;

    // write channel: address and data taken in either order
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr[5:0];
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_next.aw_full && s_next.w_full && !s_next.bvalid)
    begin
      wv = 16'(rd_word(s_reg, s_next.aw_addr));
      if (s_next.w_strb[0])
        wv[7:0] = s_next.w_data[7:0];
      if (s_next.w_strb[1])
        wv[15:8] = s_next.w_data[15:8];
      case (s_next.aw_addr)
        tpm_pkg::OFS_OVL_MODE:  s_next.ovl_mode = wv[7:0];
        tpm_pkg::OFS_PF_SET:    s_next.pf_set = wv[7:0];
        tpm_pkg::OFS_SENS_TYPE: s_next.sens_type = wv[7:0]; // RL19
        tpm_pkg::OFS_OT_RESP:   s_next.ot_resp = wv[7:0]; // RL20
        tpm_pkg::OFS_ALM_THR:   s_next.alm_thr = wv[9:0];
        tpm_pkg::OFS_FLT_THR:   s_next.flt_thr = wv[9:0];
        tpm_pkg::OFS_COOLING:   s_next.cooling = wv[7:0]; // RL18
        tpm_pkg::OFS_CLEAR:     clr = s_next.w_strb[0] && s_next.w_data[0];
        default:                clr = 1'b0;
      endcase
      s_next.bresp = mapped(s_next.aw_addr) ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
      s_next.bvalid = 1'b1;
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
    end
    // each half stalls while it holds an item or a response is pending
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready = !s_next.w_full && !s_next.bvalid;

    // read channel
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word(s_reg, araddr[5:0]);
      s_next.rresp = mapped(araddr[5:0]) ? tpm_pkg::RESP_OKAY : tpm_pkg::RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // power unit overload response
    case (s_reg.ovl_st)
      tpm_pkg::OVL_IDLE:
      begin
        s_next.pulse_freq = s_reg.pf_set;
        s_next.derate = 8'h00;
        if (unit_overload && ovl_supported(s_reg.ovl_mode))
          s_next.ovl_st = tpm_pkg::OVL_PULSE;
      end
      tpm_pkg::OVL_PULSE:
        if (unit_overload && s_reg.step_en)
        begin
          if (s_reg.pulse_freq > tpm_pkg::PF_BASE)
            s_next.pulse_freq = s_reg.pulse_freq - 8'h01; // RL1
          else if (s_reg.ovl_mode == tpm_pkg::OVL_MODE_12)
            s_next.ovl_st = tpm_pkg::OVL_DERATE; // RL4
          else
            s_next.ovl_st = tpm_pkg::OVL_TRIP; // RL3 RL8
        end
        else if (!unit_overload && s_reg.step_en)
        begin
          if (s_reg.pulse_freq < s_reg.pf_set)
            s_next.pulse_freq = s_reg.pulse_freq + 8'h01; // RL2
          else
            s_next.ovl_st = tpm_pkg::OVL_IDLE;
        end
      tpm_pkg::OVL_DERATE:
        if (unit_overload && s_reg.step_en)
        begin
          if (s_reg.derate < tpm_pkg::DERATE_MAX)
            s_next.derate = s_reg.derate + 8'h01; // RL4
          else
            s_next.ovl_st = tpm_pkg::OVL_TRIP; // RL7
        end
        else if (!unit_overload && s_reg.step_en)
        begin
          if (s_reg.derate != 8'h00)
            s_next.derate = s_reg.derate - 8'h01; // RL6
          else
            s_next.ovl_st = tpm_pkg::OVL_PULSE;
        end
      tpm_pkg::OVL_TRIP:
        if (clr)
        begin
          // drop the stage two reduction with the trip so idle never shows a stale derate
          s_next.ovl_st = tpm_pkg::OVL_IDLE;
          s_next.derate = 8'h00; // RL6
        end
      default:
        s_next.ovl_st = tpm_pkg::OVL_IDLE;
    endcase
    s_next.pu_trip = (s_next.ovl_st == tpm_pkg::OVL_TRIP);
    // only mode 3 keeps the setpoint current; 12 and 13 never derate for it
    s_next.cur_hold = (s_next.ovl_st == tpm_pkg::OVL_PULSE) &&
                      (s_reg.ovl_mode == tpm_pkg::OVL_MODE_3); // RL1 RL5

    // motor sensor classification, taken only with a fresh sample
    if (sample_valid)
    begin
      case (s_reg.sens_type)
        tpm_pkg::SENS_SWITCH: hot = sensor_ohms >= tpm_pkg::SW_OPEN_OHM; // RL9
        tpm_pkg::SENS_PTC:
        begin
          hot = sensor_ohms > tpm_pkg::PTC_HOT_OHM; // RL10
          bad = sensor_ohms < tpm_pkg::PTC_SHORT_OHM; // RL11
        end
        tpm_pkg::SENS_SI, tpm_pkg::SENS_PT:
        begin
          bad = (sensor_ohms > tpm_pkg::WIRE_OHM) || // RL15
                (s_reg.sens_type == tpm_pkg::SENS_SI ?
                 sensor_ohms < tpm_pkg::SI_SHORT_OHM : // RL16
                 sensor_ohms < tpm_pkg::PT_SHORT_OHM); // RL17
          alm = (t > s_reg.alm_thr) && (s_reg.ot_resp == tpm_pkg::OTR_ALARM); // RL12 RL13
          flt = (t > s_reg.flt_thr) ||
                ((t > s_reg.alm_thr) && (s_reg.ot_resp != tpm_pkg::OTR_ALARM)); // RL14
        end
        default: bad = 1'b0;
      endcase
      if (hot)
      begin
        alm = 1'b1;
        flt = s_reg.ot_resp != tpm_pkg::OTR_ALARM; // RL20
      end
      s_next.ota = alm; // RL22
      s_next.otf = flt;
      s_next.ilim = flt && (s_reg.ot_resp == tpm_pkg::OTR_ILIM);
      s_next.sens_bad = bad;
      s_next.sfa = bad; // RL21
    end
    // the persistence timer only runs while the fault stands
    if (!s_next.sens_bad)
      s_next.persist_cnt = 20'h00000; // RL21
    else if (s_reg.persist_cnt != PERSIST_CYC)
      s_next.persist_cnt = s_reg.persist_cnt + 20'h00001;
    if (clr)
      s_next.sft = 1'b0;
    // set after clear so a trip in the clearing cycle is kept
    if (s_reg.sens_bad && (s_reg.persist_cnt == PERSIST_CYC))
      s_next.sft = 1'b1; // RL11 RL15

    if (!aresetn)
    begin
      s_next = '0;
      s_next.ovl_mode = tpm_pkg::RST_OVL_MODE;
      s_next.pf_set = tpm_pkg::RST_PF_SET;
      s_next.sens_type = tpm_pkg::SENS_NONE; // RL19
      s_next.ot_resp = tpm_pkg::RST_OT_RESP; // RL20
      s_next.cooling = tpm_pkg::COOL_SHAFT; // RL18
      s_next.alm_thr = tpm_pkg::RST_ALM_THR;
      s_next.flt_thr = tpm_pkg::RST_FLT_THR;
      s_next.pulse_freq = tpm_pkg::RST_PF_SET;
      s_next.ovl_st = tpm_pkg::OVL_IDLE;
    end
  end

  always_ff @(posedge aclk)
  begin
    s_reg <= s_next;
  end

  assign awready                  = s_reg.awready;
  assign wready                   = s_reg.wready;
  assign bvalid                   = s_reg.bvalid;
  assign bresp                    = s_reg.bresp;
  assign arready                  = s_reg.arready;
  assign rvalid                   = s_reg.rvalid;
  assign rdata                    = s_reg.rdata;
  assign rresp                    = s_reg.rresp;
  assign pulse_freq               = s_reg.pulse_freq;
  assign output_derate            = s_reg.derate;
  assign max_cur_at_setpoint      = s_reg.cur_hold;
  assign power_unit_overtemp_trip = s_reg.pu_trip;
  assign sensor_fault_alarm       = s_reg.sfa;
  assign sensor_fault_trip        = s_reg.sft;
  assign motor_overtemp_alarm     = s_reg.ota;
  assign motor_overtemp_fault     = s_reg.otf;
  assign current_limit_reduce     = s_reg.ilim;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pulse_step_s;
    s_reg.ovl_st == tpm_pkg::OVL_PULSE && s_reg.step_en;
  endsequence

  pf_reduce_a: assert property (pulse_step_s and unit_overload && // RL1
    s_reg.pulse_freq > tpm_pkg::PF_BASE |=> pulse_freq == $past(pulse_freq) - 8'h01)
    else $error("pulse frequency not lowered");
  pf_restore_a: assert property (pulse_step_s and !unit_overload && // RL2
    s_reg.pulse_freq < s_reg.pf_set |=> pulse_freq == $past(pulse_freq) + 8'h01)
    else $error("pulse frequency not restored");
  single_trip_a: assert property (pulse_step_s and unit_overload && // RL3
    s_reg.pulse_freq <= tpm_pkg::PF_BASE && s_reg.ovl_mode != tpm_pkg::OVL_MODE_12
    |=> power_unit_overtemp_trip && output_derate == 8'h00)
    else $error("single stage trip missing");
  stage_two_a: assert property (pulse_step_s and unit_overload && // RL4
    s_reg.pulse_freq <= tpm_pkg::PF_BASE && s_reg.ovl_mode == tpm_pkg::OVL_MODE_12
    |=> s_reg.ovl_st == tpm_pkg::OVL_DERATE && !power_unit_overtemp_trip)
    else $error("stage two not entered");
  no_derate_a: assert property (output_derate != 8'h00 |-> // RL5
    s_reg.ovl_st == tpm_pkg::OVL_DERATE || s_reg.ovl_st == tpm_pkg::OVL_TRIP)
    else $error("derating outside stage two");
  derate_back_a: assert property (s_reg.ovl_st == tpm_pkg::OVL_DERATE && // RL6
    s_reg.step_en && !unit_overload && output_derate != 8'h00
    |=> output_derate == $past(output_derate) - 8'h01)
    else $error("derating not restored");
  both_fail_a: assert property (s_reg.ovl_st == tpm_pkg::OVL_DERATE && s_reg.step_en && // RL7
    unit_overload && output_derate >= tpm_pkg::DERATE_MAX |=> power_unit_overtemp_trip)
    else $error("two stage trip missing");
  switch_open_a: assert property (sample_valid && // RL9
    s_reg.sens_type == tpm_pkg::SENS_SWITCH && sensor_ohms >= tpm_pkg::SW_OPEN_OHM
    |=> motor_overtemp_alarm && motor_overtemp_fault == ($past(s_reg.ot_resp) != 8'h00))
    else $error("open switch not seen");
  ptc_hot_a: assert property (sample_valid && // RL10
    s_reg.sens_type == tpm_pkg::SENS_PTC && sensor_ohms > tpm_pkg::PTC_HOT_OHM
    |=> motor_overtemp_alarm)
    else $error("thermistor overtemperature missed");
  persist_trip_a: assert property (s_reg.sens_bad && // RL11
    s_reg.persist_cnt == PERSIST_CYC - 20'h00001 && !sensor_fault_trip
    |=> !sensor_fault_trip ##1 sensor_fault_trip)
    else $error("sensor trip timing wrong");
  si_short_a: assert property (sample_valid && // RL16
    s_reg.sens_type == tpm_pkg::SENS_SI && sensor_ohms < tpm_pkg::SI_SHORT_OHM
    |=> sensor_fault_alarm)
    else $error("silicon short missed");
  pt_short_a: assert property (sample_valid && // RL17
    s_reg.sens_type == tpm_pkg::SENS_PT && sensor_ohms < tpm_pkg::PT_SHORT_OHM
    |=> sensor_fault_alarm)
    else $error("platinum short missed");
  alarm_clear_a: assert property (sample_valid && s_reg.sens_type == tpm_pkg::SENS_PTC && // RL21
    sensor_ohms >= tpm_pkg::PTC_SHORT_OHM |=> !sensor_fault_alarm ##1 s_reg.persist_cnt == 20'h0)
    else $error("sensor alarm not cleared");

  trip_seen_c: cover property (s_reg.ovl_st == tpm_pkg::OVL_DERATE ##[1:1000]
    power_unit_overtemp_trip);
  restore_c: cover property (s_reg.ovl_st == tpm_pkg::OVL_PULSE ##1
    s_reg.ovl_st == tpm_pkg::OVL_IDLE);
  sens_trip_c: cover property ($rose(sensor_fault_trip));
endmodule
`default_nettype wire

/* File: bench/tpm_sensor_model.sv */
// motor sensor and power stage model feeding the monitor
`timescale 1ns/1ps
`default_nettype none
module tpm_sensor_model (
  input  wire logic              aclk,
  input  wire logic              fire,
  input  wire logic [15:0]       ohms_set,
  input  wire logic signed [9:0] temp_set,
  input  wire logic              hot,
  output logic                   sample_valid,
  output logic [15:0]            sensor_ohms,
  output logic signed [9:0]      motor_temp,
  output logic                   unit_overload
);
  // between samples the lines carry inverted junk, so a stale value can never pass
  always_ff @(posedge aclk)
  begin
    sample_valid  <= fire;
    sensor_ohms   <= fire ? ohms_set : ~sensor_ohms;
    motor_temp    <= fire ? temp_set : ~motor_temp;
    unit_overload <= hot;
  end
endmodule
`default_nettype wire

/* File: bench/thermal_protection_monitor_test.sv */
// self-checking bench of the thermal protection monitor
`timescale 1ns/1ps
`default_nettype none
module thermal_protection_monitor_test;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, hot;
  logic [31:0]       awaddr, wdata, araddr, rdata, rd_val;
  logic [3:0]        wstrb;
  logic [15:0]       ohms_set, sensor_ohms;
  logic signed [9:0] temp_set, motor_temp;
  logic              awready, wready, bvalid, arready, rvalid, sample_valid, unit_overload;
  logic [1:0]        bresp, rresp, rd_resp, wr_resp;
  logic [7:0]        pulse_freq, output_derate;
  logic              max_cur_at_setpoint, power_unit_overtemp_trip, current_limit_reduce;
  logic              sensor_fault_alarm, sensor_fault_trip, motor_overtemp_alarm, motor_overtemp_fault;
  int                errors, checks, cycles;

  tpm_monitor #(.PERSIST_CYC(20'h00014), .STEP_CYC(16'h0004)) uut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .unit_overload, .sample_valid, .sensor_ohms, .motor_temp, .pulse_freq,
    .output_derate, .max_cur_at_setpoint, .power_unit_overtemp_trip, .sensor_fault_alarm,
    .sensor_fault_trip, .motor_overtemp_alarm, .motor_overtemp_fault, .current_limit_reduce);

  tpm_sensor_model partner (.aclk, .fire, .ohms_set, .temp_set, .hot, .sample_valid,
    .sensor_ohms, .motor_temp, .unit_overload);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang costs a mismatch rather than an endless run
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= {26'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr  <= {26'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_val  = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  // the partner forwards one edge late, the monitor registers one edge later
  task automatic smp(input logic [15:0] o, input logic signed [9:0] t);
    @(posedge aclk);
    ohms_set <= o;
    temp_set <= t;
    fire     <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (2) @(negedge aclk);
  endtask

  task automatic t_regs();
    logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h02, 8'h80};
    rd(6'h0C);
    chk("response reset", rd_val, 32'h0000000C);
    rd(6'h08);
    chk("sensor type reset", rd_val, 32'h00000000);
    rd(6'h18);
    chk("cooling reset", rd_val, 32'h00000000);
    rd(6'h30);
    chk("unmapped resp", 32'(rd_resp), 32'h00000002);
    wr(6'h30, 32'h00000001);
    chk("unmapped write", 32'(wr_resp), 32'h00000002);
    wr(6'h18, 32'h00000002);
    chk("mapped write", 32'(wr_resp), 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h18, 32'(codes[i]));
      rd(6'h20);
      chk("cooling decode", 32'(rd_val[12:9]), 32'(4'h1 << i));
    end
  endtask

  task automatic t_persist();
    wr(6'h08, 32'h00000001);
    smp(16'h000A, 10'sh014);
    chk("short alarm", 32'(sensor_fault_alarm), 32'h1);
    repeat (10) @(posedge aclk);
    chk("early trip", 32'(sensor_fault_trip), 32'h0);
    repeat (20) @(posedge aclk);
    chk("late trip", 32'(sensor_fault_trip), 32'h1);
    smp(16'h01F4, 10'sh014);
    chk("alarm gone", 32'(sensor_fault_alarm), 32'h0);
    wr(6'h1C, 32'h00000001);
    smp(16'h000A, 10'sh014);
    repeat (12) @(posedge aclk);
    smp(16'h01F4, 10'sh014);
    smp(16'h000A, 10'sh014);
    repeat (12) @(posedge aclk);
    chk("timer restart", 32'(sensor_fault_trip), 32'h0);
    smp(16'h01F4, 10'sh014);
  endtask

  task automatic t_sensors();
    logic [7:0]  ty [10] = '{8'h04, 8'h04, 8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h06, 8'h06, 8'h06};
    logic [15:0] om [10] = '{16'h0064, 16'h0063, 16'h0673, 16'h0672, 16'h0849, 16'h0031,
                             16'h0032, 16'h025A, 16'h025B, 16'h0848};
    logic [1:0]  ex [10] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0};
    for (int i = 0; i < 10; i++)
    begin
      wr(6'h08, 32'(ty[i]));
      smp(om[i], 10'sh014);
      chk("classify", 32'({sensor_fault_alarm, motor_overtemp_alarm}), 32'(ex[i]));
    end
  endtask

  task automatic t_temp();
    wr(6'h08, 32'h00000006);
    wr(6'h0C, 32'h00000000);
    smp(16'h03E8, 10'sh083);
    chk("alarm only", 32'({motor_overtemp_alarm, motor_overtemp_fault}), 32'h2);
    smp(16'h03E8, 10'sh082);
    chk("at threshold", 32'({motor_overtemp_alarm, motor_overtemp_fault}), 32'h0);
    smp(16'h03E8, 10'sh092);
    chk("fault level", 32'(motor_overtemp_fault), 32'h1);
    wr(6'h0C, 32'h00000001);
    smp(16'h03E8, 10'sh083);
    chk("fault by response", 32'({motor_overtemp_fault, current_limit_reduce}), 32'h3);
  endtask

  task automatic t_overload();
    wr(6'h00, 32'h00000003);
    @(posedge aclk) hot <= 1'b1;
    repeat (300) if (pulse_freq !== 8'h03) @(posedge aclk);
    chk("mode 3 current", 32'(max_cur_at_setpoint), 32'h1);
    @(posedge aclk) hot <= 1'b0;
    repeat (300) if (pulse_freq !== 8'h04) @(posedge aclk);
    chk("pulse restored", 32'(pulse_freq), 32'h4);
    wr(6'h00, 32'h0000000D);
    @(posedge aclk) hot <= 1'b1;
    repeat (300) if (power_unit_overtemp_trip !== 1'b1) @(posedge aclk);
    chk("mode 13 trip", 32'({power_unit_overtemp_trip, output_derate, pulse_freq}), 32'h10002);
    @(posedge aclk) hot <= 1'b0;
    wr(6'h1C, 32'h00000001);
    wr(6'h00, 32'h0000000C);
    @(posedge aclk) hot <= 1'b1;
    repeat (300) if (output_derate !== 8'h02) @(posedge aclk);
    chk("stage two", 32'({power_unit_overtemp_trip, pulse_freq}), 32'h002);
    @(posedge aclk) hot <= 1'b0;
    repeat (300) if (pulse_freq !== 8'h04) @(posedge aclk);
    chk("stage two undone", 32'(output_derate), 32'h0);
    @(posedge aclk) hot <= 1'b1;
    repeat (900) if (power_unit_overtemp_trip !== 1'b1) @(posedge aclk);
    chk("mode 12 trip", 32'({power_unit_overtemp_trip, output_derate}), 32'h132);
    @(posedge aclk) hot <= 1'b0;
    wr(6'h1C, 32'h00000001);
    chk("trip cleared", 32'(power_unit_overtemp_trip), 32'h0);
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, hot} = '0;
    {awaddr, wdata, araddr, ohms_set, temp_set} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_persist();
    t_sensors();
    t_temp();
    t_overload();
    complete_run();
  end
endmodule
`default_nettype wire
